// ==== dv/escc_sva.sv ====
// port checker for the extended sequencer clock control bank
`timescale 1ns/1ps
module escc_chk #(
  parameter int DAC_CNT_W = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [15:0] host_addr_i,
  input wire logic host_mmio_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [1:0] crtc_clock_select_field_i,
  input wire logic standby_i,
  input wire logic suspend_i,
  input wire logic local_bus_enable_i,
  input wire logic host_rvalid_o,
  input wire logic port_io_decode_o,
  input wire logic pixel_data_bus_oe_n_o,
  input wire logic local_bus_enable_out_o,
  input wire logic [1:0] hsync_ctl_o,
  input wire logic [1:0] vsync_ctl_o,
  input wire logic vdclk1_stop_o,
  input wire logic tdclk1_stop_o,
  input wire logic [4:0] mclk_n_o,
  input wire logic [6:0] mclk_m_o,
  input wire logic [DAC_CNT_W-1:0] dac_test_cnt_o
);
  // ==========================================================
  // properties, one clock domain
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  property p_rd_ans;
    ce_i && host_rd_i && host_mmio_i && host_addr_i[15:1] == 15'h01e2
      |=> host_rvalid_o;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
  property p_no_rd;
    ce_i && !host_rd_i |=> !host_rvalid_o;
  endproperty
  a_no_rd: assert property (p_no_rd) else $error("stray read pulse");
  // port reads refused while port decoding is off
  property p_pio_off;
    ce_i && host_rd_i && !host_mmio_i && !port_io_decode_o
      && !$past(host_wr_i) |=> !host_rvalid_o;
  endproperty
  a_pio_off: assert property (p_pio_off) else $error("port read");
  property p_lpb;
    ce_i && !$past(rst_i) && local_bus_enable_i |=> local_bus_enable_out_o;
  endproperty
  a_lpb: assert property (p_lpb) else $error("bus enable lost");
  property p_vd_off;
    ce_i && !$past(rst_i) && crtc_clock_select_field_i != 2'b11
      && !standby_i && !suspend_i |=> !vdclk1_stop_o;
  endproperty
  a_vd_off: assert property (p_vd_off) else $error("vclk stopped");
  property p_td_off;
    ce_i && !$past(rst_i) && !standby_i && !suspend_i |=> !tdclk1_stop_o;
  endproperty
  a_td_off: assert property (p_td_off) else $error("tclk stopped");
  // mode and divider outputs move only after a register write
  property p_mode_src;
    $changed({hsync_ctl_o, vsync_ctl_o, pixel_data_bus_oe_n_o})
      |-> $past(host_wr_i) || $past(host_wr_i, 2);
  endproperty
  a_mode_src: assert property (p_mode_src) else $error("mode moved");
  property p_div_src;
    $changed({mclk_n_o, mclk_m_o}) |-> $past(host_wr_i)
      || $past(host_wr_i, 2) || $past(host_wr_i, 3);
  endproperty
  a_div_src: assert property (p_div_src) else $error("div moved");
  property p_cnt;
    $changed(dac_test_cnt_o) |-> dac_test_cnt_o == '0
      || dac_test_cnt_o == DAC_CNT_W'($past(dac_test_cnt_o) + 1);
  endproperty
  a_cnt: assert property (p_cnt) else $error("counter jumped");
  c_read: cover property (host_rvalid_o);
  c_pio: cover property (host_rd_i && !host_mmio_i && !port_io_decode_o);
  c_cnt: cover property ($changed(dac_test_cnt_o));
endmodule // escc_chk

// ==== dv/escc_tb.sv ====
// self-checking bench for the extended sequencer clock control bank
`timescale 1ns/1ps
module testbench;
  logic core_clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
  logic host_mmio_i = 1'b0, host_wr_i = 1'b0, host_rd_i = 1'b0;
  logic standby_i = 1'b0, suspend_i = 1'b0, local_bus_enable_i = 1'b0;
  logic [15:0] host_addr_i = 16'h0000;
  logic [7:0] host_wdata_i = 8'h00;
  logic [1:0] crtc_clock_select_field_i = 2'h0;
  logic [7:0] host_rdata_o, dot_clock_m_o, dac_test_cnt_o, cnt_v;
  logic [6:0] mclk_m_o;
  logic [5:0] dot_clock_n_o;
  logic [4:0] mclk_n_o;
  logic [2:0] dac_route_o;
  logic [1:0] mclk_r_o, dot_clock_r_o, hsync_ctl_o, vsync_ctl_o;
  logic host_rvalid_o, port_io_decode_o, pixel_data_bus_oe_n_o;
  logic two_mclk_write_o, local_bus_enable_out_o, vdclk1_stop_o;
  logic tdclk1_stop_o, dot_clock_pll_pd_o, mclk_pll_pd_o, synth_cnt_clr_o;
  logic mclk_ext_o, dot_clock_ext_o, dot_clock_div2_o, dot_clock_inv_o, dac_pd_o;
  logic clut_one_cycle_o, dac_clk_double_o;
  int err_count = 0, checked = 0, cyc = 0;
  escc_top #(.DAC_CNT_W(8)) dut (.*);
  // ==========================================================
  // clock, timeout and shared tasks
  always #2 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // one host cycle, strobe held for exactly one edge
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [7:0] d);
    idle(1);
    host_wr_i = w;
    host_rd_i = ~w;
    host_addr_i = a;
    host_wdata_i = d;
    idle(1);
    host_wr_i = 1'b0;
    host_rd_i = 1'b0;
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    acc(1'b1, escc_pkg::PORT_INDEX, ix);
    acc(1'b1, escc_pkg::PORT_DATA, d);
    idle(4);
  endtask
  task automatic rd(input logic [7:0] ix, input logic [7:0] exp,
                    input logic ans);
    acc(1'b1, escc_pkg::PORT_INDEX, ix);
    acc(1'b0, escc_pkg::PORT_DATA, 8'h00);
    chk(host_rvalid_o, ans);
    if (ans) chk(host_rdata_o, exp);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_lock();
    rd(8'h0a, 8'h00, 1'b1);
    wr(8'h0a, 8'ha0);
    chk(pixel_data_bus_oe_n_o, 1'b1);
    wr(8'h08, 8'hf6);
    rd(8'h08, 8'hf6, 1'b1);
    wr(8'h0a, 8'ha0);
    chk(pixel_data_bus_oe_n_o, 1'b0);
    chk(two_mclk_write_o, 1'b0);
    wr(8'h15, 8'h80);
    chk(two_mclk_write_o, 1'b1);
    wr(8'h08, 8'h07);
    wr(8'h0a, 8'h00);
    chk(pixel_data_bus_oe_n_o, 1'b0);
    wr(8'h08, 8'h06);
    rd(8'h0b, 8'h00, 1'b1);
  endtask
  task automatic t_sync();
    wr(8'h0d, 8'hb1);
    chk(hsync_ctl_o, 2'h3);
    chk(vsync_ctl_o, 2'h2);
    chk(local_bus_enable_out_o, 1'b1);
    wr(8'h0d, 8'h00);
    chk(local_bus_enable_out_o, 1'b0);
    local_bus_enable_i = 1'b1;
    idle(2);
    chk(local_bus_enable_out_o, 1'b1);
  endtask
  task automatic t_gate();
    logic [7:0] cfg [3] = '{8'h04, 8'h28, 8'h50};
    logic [3:0] stim [3] = '{4'h3, 4'h4, 4'h8};
    logic [1:0] ex [3] = '{2'b10, 2'b11, 2'b11};
    for (int i = 0; i < 3; i++) begin
      wr(8'h09, cfg[i]);
      {suspend_i, standby_i, crtc_clock_select_field_i} = stim[i];
      idle(2);
      chk({vdclk1_stop_o, tdclk1_stop_o}, ex[i]);
      {suspend_i, standby_i, crtc_clock_select_field_i} = stim[(i+1)%3];
      idle(2);
      chk({vdclk1_stop_o, tdclk1_stop_o}, 2'b00);
    end
    {suspend_i, standby_i, crtc_clock_select_field_i} = 4'h0;
  endtask
  task automatic t_synth();
    wr(8'h10, 8'h7f);
    wr(8'h11, 8'h55);
    wr(8'h12, 8'hc5);
    wr(8'h13, 8'ha3);
    chk(mclk_m_o, 7'h00);
    wr(8'h15, 8'h01);
    chk({mclk_r_o, mclk_n_o}, 7'h7f);
    chk(mclk_m_o, 7'h55);
    chk(dot_clock_m_o, 8'h00);
    wr(8'h15, 8'h02);
    chk({dot_clock_r_o, dot_clock_n_o}, 8'hc5);
    chk(dot_clock_m_o, 8'ha3);
    wr(8'h15, 8'h20);
    wr(8'h10, 8'h21);
    chk({mclk_r_o, mclk_n_o}, 7'h21);
    wr(8'h14, 8'hd3);
    chk({dot_clock_ext_o, mclk_ext_o, synth_cnt_clr_o, mclk_pll_pd_o,
         dot_clock_pll_pd_o}, 5'h1f);
    wr(8'h14, 8'h2c);
    chk({dot_clock_ext_o, mclk_ext_o, synth_cnt_clr_o, mclk_pll_pd_o,
         dot_clock_pll_pd_o}, 5'h00);
    wr(8'h15, 8'h50);
    chk({dot_clock_inv_o, dot_clock_div2_o}, 2'h3);
  endtask
  task automatic t_dac();
    wr(8'h18, 8'hdd);
    chk({dac_clk_double_o, clut_one_cycle_o, dac_pd_o, dac_route_o},
        6'h37);
    cnt_v = dac_test_cnt_o;
    idle(3);
    chk(dac_test_cnt_o, cnt_v + 8'h03);
    ce_i = 1'b0;
    idle(3);
    ce_i = 1'b1;
    chk(dac_test_cnt_o, cnt_v + 8'h03);
    wr(8'h18, 8'h03);
    chk(dac_test_cnt_o, 8'h00);
    wr(8'h18, 8'h20);
    chk({dac_pd_o, dac_test_cnt_o[6:0]}, 8'h80);
  endtask
  task automatic t_mmio();
    host_mmio_i = 1'b1;
    wr(8'h09, 8'h80);
    host_mmio_i = 1'b0;
    chk(port_io_decode_o, 1'b0);
    rd(8'h08, 8'h00, 1'b0);
    host_mmio_i = 1'b1;
    rd(8'h08, 8'h06, 1'b1);
    wr(8'h09, 8'h00);
    host_mmio_i = 1'b0;
    chk(port_io_decode_o, 1'b1);
  endtask
  task automatic finish_test();
    $display("Checks %0d, errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    idle(8);
    rst_i = 1'b0;
    chk(port_io_decode_o, 1'b1);
    chk(pixel_data_bus_oe_n_o, 1'b1);
    t_lock();
    t_sync();
    t_gate();
    t_synth();
    t_dac();
    t_mmio();
    finish_test();
  end
endmodule // testbench
bind escc_top escc_chk #(.DAC_CNT_W(DAC_CNT_W)) u_chk (.*);

// ==== hdl/escc_pkg.sv ====
// constants for the extended sequencer clock control block
package escc_pkg;
  // host port addresses of the sequencer index and data
  localparam logic [15:0] PORT_INDEX = 16'h03c4;
  localparam logic [15:0] PORT_DATA = 16'h03c5;
  // register indexes
  localparam logic [4:0] IX_UNLOCK = 5'h08;
  localparam logic [4:0] IX_GATE_IO = 5'h09;
  localparam logic [4:0] IX_BUS_WR = 5'h0a;
  localparam logic [4:0] IX_SYNC_LPB = 5'h0d;
  localparam logic [4:0] IX_MCLK_LO = 5'h10;
  localparam logic [4:0] IX_MCLK_HI = 5'h11;
  localparam logic [4:0] IX_DOT_CLOCK_LO = 5'h12;
  localparam logic [4:0] IX_DOT_CLOCK_HI = 5'h13;
  localparam logic [4:0] IX_SYN_CTL1 = 5'h14;
  localparam logic [4:0] IX_SYN_CTL2 = 5'h15;
  localparam logic [4:0] IX_SYN_TSTA = 5'h16;
  localparam logic [4:0] IX_SYN_TSTB = 5'h17;
  localparam logic [4:0] IX_DAC_CTL = 5'h18;
  localparam int NUM_IX = 32;
  // indexes that hold storage in this block
  localparam logic [31:0] IX_IMPL = 32'h01ff2700;
  // unlock code in the low nibble
  localparam logic [3:0] UNLOCK_CODE = 4'h6;
  localparam logic [7:0] REG_RESET = 8'h00;
  // field positions
  localparam int B_VDCLK_SEL = 2;
  localparam int B_VDCLK_SBY = 3;
  localparam int B_VDCLK_SUS = 4;
  localparam int B_TDCLK_SBY = 5;
  localparam int B_TDCLK_SUS = 6;
  localparam int B_MMIO_ONLY = 7;
  localparam int B_PD_DRIVE = 5;
  localparam int B_TWO_MCLK = 7;
  localparam int B_LPB_ONE = 0;
  localparam int B_HSYNC_LO = 4;
  localparam int B_VSYNC_LO = 6;
  localparam int B_DPLL_PD = 0;
  localparam int B_MPLL_PD = 1;
  localparam int B_CNT_CLR = 4;
  localparam int B_MCLK_EXT = 6;
  localparam int B_DOT_CLOCK_EXT = 7;
  localparam int B_LD_MCLK = 0;
  localparam int B_LD_DOT_CLOCK = 1;
  localparam int B_DOT_CLOCK_DIV2 = 4;
  localparam int B_LD_NOW = 5;
  localparam int B_DOT_CLOCK_INV = 6;
  localparam int B_TWO_MCLK_EN = 7;
  localparam int B_DAC_CNT_EN = 0;
  localparam int B_DAC_CNT_RST = 1;
  localparam int B_DAC_RED = 2;
  localparam int B_DAC_PD = 5;
  localparam int B_CLUT_1CYC = 6;
  localparam int B_DAC_DBL = 7;
  localparam logic [1:0] CRTC_SEL_STOP = 2'b11;
endpackage : escc_pkg

// ==== hdl/escc_top.sv ====
// extended sequencer register bank with clock synthesizer controls
`timescale 1ns/1ps
// How it works
// - unlock code 0110b opens indexes 09h-18h
// - mmio-only bit stops port decoding
// - bit drives pixel data bus
// - two-clock memory writes from bus timing bit
// - bus enable held high when set
// - hsync and vsync power fields
// - virtual dot clock stops on crtc 11b
// - standby/suspend gate controller 1 clocks
// - memory clock n, r, m fields
// - dot clock n, r, m fields
// - test power-down of both loops
// - test clear of synthesizer counters
// - test external memory and dot clocks
// - load bits apply new divider values
// - immediate bit applies values at once
// - enable bit for two-clock writes
// - dac test counter count and reset
// - route red, green, blue to bus
// - single cycle clut write select
// - palette dac clock-doubled mode
module escc_top #(
  parameter int DAC_CNT_W = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [15:0] host_addr_i,
  input wire logic host_mmio_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [7:0] host_wdata_i,
  input wire logic [1:0] crtc_clock_select_field_i,
  input wire logic standby_i,
  input wire logic suspend_i,
  input wire logic local_bus_enable_i,
  output logic [7:0] host_rdata_o,
  output logic host_rvalid_o,
  output logic port_io_decode_o,
  output logic pixel_data_bus_oe_n_o,
  output logic two_mclk_write_o,
  output logic local_bus_enable_out_o,
  output logic [1:0] hsync_ctl_o,
  output logic [1:0] vsync_ctl_o,
  output logic vdclk1_stop_o,
  output logic tdclk1_stop_o,
  output logic [4:0] mclk_n_o,
  output logic [1:0] mclk_r_o,
  output logic [6:0] mclk_m_o,
  output logic [5:0] dot_clock_n_o,
  output logic [1:0] dot_clock_r_o,
  output logic [7:0] dot_clock_m_o,
  output logic dot_clock_pll_pd_o,
  output logic mclk_pll_pd_o,
  output logic synth_cnt_clr_o,
  output logic mclk_ext_o,
  output logic dot_clock_ext_o,
  output logic dot_clock_div2_o,
  output logic dot_clock_inv_o,
  output logic [DAC_CNT_W-1:0] dac_test_cnt_o,
  output logic [2:0] dac_route_o,
  output logic dac_pd_o,
  output logic clut_one_cycle_o,
  output logic dac_clk_double_o
);

  // ==========================================================
  // host access decode
  // ==========================================================
  logic [7:0] index_r;
  logic [7:0] regs_r [escc_pkg::NUM_IX];
  logic unlocked;
  logic mmio_only;
  logic access_ok;
  logic idx_wr;
  logic data_wr;
  logic data_rd;
  logic idx_rd;
  logic [4:0] ix;
  logic ix_in_range;

  // current index and lock state
  assign ix = index_r[4:0];
  assign ix_in_range = (index_r[7:5] == 3'h0);
  // only the low nibble is compared; the upper bits store freely
  assign unlocked = (regs_r[escc_pkg::IX_UNLOCK][3:0]
                     == escc_pkg::UNLOCK_CODE);
  assign mmio_only = regs_r[escc_pkg::IX_GATE_IO][escc_pkg::B_MMIO_ONLY];

  // port cycles are dropped when mmio-only is set
  // every strobe is qualified by ce_i so a frozen block takes nothing
  assign access_ok = host_mmio_i | ~mmio_only;
  assign idx_wr = ce_i & access_ok & host_wr_i
                  & (host_addr_i == escc_pkg::PORT_INDEX);
  assign idx_rd = ce_i & access_ok & host_rd_i
                  & (host_addr_i == escc_pkg::PORT_INDEX);
  assign data_wr = ce_i & access_ok & host_wr_i
                   & (host_addr_i == escc_pkg::PORT_DATA);
  assign data_rd = ce_i & access_ok & host_rd_i
                   & (host_addr_i == escc_pkg::PORT_DATA);

  // index register
  // it is never protected so the unlock entry stays reachable
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      index_r <= 8'h00;
    end else if (idx_wr) begin
      index_r <= host_wdata_i;
    end
  end

  // ==========================================================
  // register storage, one entry per implemented index
  // ==========================================================
  genvar gi;
  generate
    for (gi = 0; gi < escc_pkg::NUM_IX; gi++) begin : g_reg
      // entries without storage read zero and drop writes
      if (escc_pkg::IX_IMPL[gi]) begin : g_impl
        logic wr_en;
        // unlock register always writable, others need unlock
        assign wr_en = data_wr & ix_in_range & (ix == gi)
                       & ((ix == escc_pkg::IX_UNLOCK)
                          | unlocked);
        always_ff @(posedge core_clk_i or posedge rst_i) begin
          if (rst_i) begin
            regs_r[gi] <= escc_pkg::REG_RESET;
          end else if (wr_en) begin
            regs_r[gi] <= host_wdata_i;
          end
        end
      end else begin : g_none
        assign regs_r[gi] = 8'h00;
      end
    end
  endgenerate

  // ==========================================================
  // read path
  // ==========================================================
  logic [7:0] rd_mux;

  // protected indexes read zero while locked
  always_comb begin
    rd_mux = 8'h00;
    if (idx_rd) begin
      rd_mux = index_r;
    end else if (ix_in_range
                 & ((ix == escc_pkg::IX_UNLOCK) | unlocked)) begin
      rd_mux = regs_r[ix];
    end
  end

  // read data and valid pulse
  // a locked read still pulses valid so the host never waits
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      host_rdata_o <= 8'h00;
      host_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      host_rvalid_o <= idx_rd | data_rd;
      if (idx_rd | data_rd) begin
        host_rdata_o <= rd_mux;
      end
    end
  end

  // ==========================================================
  // bus, write timing and sync controls
  // ==========================================================
  logic [7:0] gate_r;
  logic [7:0] buswr_r;
  logic [7:0] sync_r;
  logic [7:0] ctl1_r;
  logic [7:0] ctl2_r;
  logic [7:0] dac_r;

  // named views of the stored control registers
  assign gate_r = regs_r[escc_pkg::IX_GATE_IO];
  assign buswr_r = regs_r[escc_pkg::IX_BUS_WR];
  assign sync_r = regs_r[escc_pkg::IX_SYNC_LPB];
  assign ctl1_r = regs_r[escc_pkg::IX_SYN_CTL1];
  assign ctl2_r = regs_r[escc_pkg::IX_SYN_CTL2];
  assign dac_r = regs_r[escc_pkg::IX_DAC_CTL];

  // registered copies of bus and sync controls
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      // port decoding starts on and the pixel bus floats
      port_io_decode_o <= 1'b1;
      pixel_data_bus_oe_n_o <= 1'b1;
      two_mclk_write_o <= 1'b0;
      local_bus_enable_out_o <= 1'b0;
      hsync_ctl_o <= 2'b00;
      vsync_ctl_o <= 2'b00;
    end else if (ce_i) begin
      port_io_decode_o <= ~mmio_only;
      // oe low means the pixel bus is driven
      pixel_data_bus_oe_n_o <= ~buswr_r[escc_pkg::B_PD_DRIVE];
      two_mclk_write_o <= buswr_r[escc_pkg::B_TWO_MCLK]
                          & ctl2_r[escc_pkg::B_TWO_MCLK_EN];
      local_bus_enable_out_o <= sync_r[escc_pkg::B_LPB_ONE]
                                | local_bus_enable_i;
      hsync_ctl_o <= sync_r[escc_pkg::B_HSYNC_LO +: 2];
      vsync_ctl_o <= sync_r[escc_pkg::B_VSYNC_LO +: 2];
    end
  end

  // ==========================================================
  // controller 1 clock gating
  // ==========================================================
  logic vdclk_stop;
  logic tdclk_stop;

  // virtual dot clock stops on crtc select or power state
  assign vdclk_stop =
    (gate_r[escc_pkg::B_VDCLK_SEL]
     & (crtc_clock_select_field_i == escc_pkg::CRTC_SEL_STOP))
    | (gate_r[escc_pkg::B_VDCLK_SBY] & standby_i)
    | (gate_r[escc_pkg::B_VDCLK_SUS] & suspend_i);
  // true dot clock stops in standby or suspend only
  assign tdclk_stop =
    (gate_r[escc_pkg::B_TDCLK_SBY] & standby_i)
    | (gate_r[escc_pkg::B_TDCLK_SUS] & suspend_i);

  // stop controls are registered so they never glitch
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      vdclk1_stop_o <= 1'b0;
      tdclk1_stop_o <= 1'b0;
    end else if (ce_i) begin
      vdclk1_stop_o <= vdclk_stop;
      tdclk1_stop_o <= tdclk_stop;
    end
  end

  // ==========================================================
  // synthesizer divider values
  // ==========================================================
  logic [7:0] mlo;
  logic [7:0] mhi;
  logic [7:0] dlo;
  logic [7:0] dhi;
  logic ld_now;
  logic ld_mclk;
  logic ld_dot_clock;

  // divider bytes as software wrote them
  assign mlo = regs_r[escc_pkg::IX_MCLK_LO];
  assign mhi = regs_r[escc_pkg::IX_MCLK_HI];
  assign dlo = regs_r[escc_pkg::IX_DOT_CLOCK_LO];
  assign dhi = regs_r[escc_pkg::IX_DOT_CLOCK_HI];
  // values go to the loops while a load bit or immediate bit is set
  // a held load bit tracks later writes; clear it to freeze
  assign ld_now = ctl2_r[escc_pkg::B_LD_NOW];
  assign ld_mclk = ctl2_r[escc_pkg::B_LD_MCLK] | ld_now;
  assign ld_dot_clock = ctl2_r[escc_pkg::B_LD_DOT_CLOCK] | ld_now;

  // memory clock active values
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mclk_n_o <= 5'h00;
      mclk_r_o <= 2'h0;
      mclk_m_o <= 7'h00;
    end else if (ce_i & ld_mclk) begin
      mclk_n_o <= mlo[4:0];
      mclk_r_o <= mlo[6:5];
      mclk_m_o <= mhi[6:0];
    end
  end

  // dot clock active values
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dot_clock_n_o <= 6'h00;
      dot_clock_r_o <= 2'h0;
      dot_clock_m_o <= 8'h00;
    end else if (ce_i & ld_dot_clock) begin
      dot_clock_n_o <= dlo[5:0];
      dot_clock_r_o <= dlo[7:6];
      dot_clock_m_o <= dhi[7:0];
    end
  end

  // ==========================================================
  // synthesizer test and option controls
  // ==========================================================
  // test and option bits, one cycle behind the register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dot_clock_pll_pd_o <= 1'b0;
      mclk_pll_pd_o <= 1'b0;
      synth_cnt_clr_o <= 1'b0;
      mclk_ext_o <= 1'b0;
      dot_clock_ext_o <= 1'b0;
      dot_clock_div2_o <= 1'b0;
      dot_clock_inv_o <= 1'b0;
    end else if (ce_i) begin
      dot_clock_pll_pd_o <= ctl1_r[escc_pkg::B_DPLL_PD];
      mclk_pll_pd_o <= ctl1_r[escc_pkg::B_MPLL_PD];
      synth_cnt_clr_o <= ctl1_r[escc_pkg::B_CNT_CLR];
      mclk_ext_o <= ctl1_r[escc_pkg::B_MCLK_EXT];
      dot_clock_ext_o <= ctl1_r[escc_pkg::B_DOT_CLOCK_EXT];
      dot_clock_div2_o <= ctl2_r[escc_pkg::B_DOT_CLOCK_DIV2];
      dot_clock_inv_o <= ctl2_r[escc_pkg::B_DOT_CLOCK_INV];
    end
  end

  // ==========================================================
  // palette dac controls and test counter
  // ==========================================================
  // reset wins over counting
  // the count wraps; its width is a parameter
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dac_test_cnt_o <= '0;
    end else if (ce_i) begin
      if (dac_r[escc_pkg::B_DAC_CNT_RST]) begin
        dac_test_cnt_o <= '0;
      end else if (dac_r[escc_pkg::B_DAC_CNT_EN]) begin
        dac_test_cnt_o <= dac_test_cnt_o + 1'b1;
      end
    end
  end

  // dac mode outputs
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dac_route_o <= 3'h0;
      dac_pd_o <= 1'b0;
      clut_one_cycle_o <= 1'b0;
      dac_clk_double_o <= 1'b0;
    end else if (ce_i) begin
      // bit 0 red, bit 1 green, bit 2 blue
      dac_route_o <= dac_r[escc_pkg::B_DAC_RED +: 3];
      dac_pd_o <= dac_r[escc_pkg::B_DAC_PD];
      clut_one_cycle_o <= dac_r[escc_pkg::B_CLUT_1CYC];
      dac_clk_double_o <= dac_r[escc_pkg::B_DAC_DBL];
    end
  end

endmodule // escc_top
